//--- design/supervisor_pkg.sv
// Constants and helpers for the supply supervisor with window watchdog.
// Assumes a single 20 MHz system clock and no software-visible registers.
package supervisor_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ          = 64'd20_000_000;
    localparam longint unsigned MS_PER_S        = 64'd1000;
    localparam longint unsigned WD_PERIOD_MS    = 64'd100;
    localparam int unsigned     WD_PERIOD_CYC   =
        int'((WD_PERIOD_MS * CLK_HZ) / MS_PER_S);

    // Window proportions of the watchdog period
    localparam int unsigned CLOSED_NUM      = 32'd4;
    localparam int unsigned CLOSED_DEN      = 32'd5;
    localparam int unsigned OPEN_NUM        = 32'd2;
    localparam int unsigned OPEN_DEN        = 32'd5;
    localparam int unsigned PULSE_NUM       = 32'd1;
    localparam int unsigned PULSE_DEN       = 32'd40;

    // Valid clears needed before the enable output goes active
    localparam logic [1:0]  KICKS_FOR_ENABLE = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_STARTUP = 2'h0,
        ST_CLOSED  = 2'h1,
        ST_OPEN    = 2'h3,
        ST_PULSE   = 2'h2
    } wd_state_type;

    // Fraction of a period in cycles, rounded down, never below one
    function automatic logic [31:0] period_part(
        input logic [31:0] period,
        input int unsigned num,
        input int unsigned den
    );
        longint unsigned prod;
        prod = (longint'(period) * num) / den;
        if (prod == 64'd0) begin
            period_part = 32'h1;
        end else begin
            period_part = prod[31:0];
        end
    endfunction : period_part

endpackage : supervisor_pkg

//--- design/supply_level_filter.sv
// Supply level qualifier: synchronises the two comparator results and
// applies hysteresis. Assumes both comparator inputs are asynchronous.
`timescale 1ns/100ps
module supply_level_filter
    import supervisor_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Comparator results
    input  wire logic above_ref_i,
    input  wire logic above_release_i,
    // Qualified supply state
    output logic      supply_ok_o
);

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    logic [1:0] ref_sync;
    logic [1:0] rel_sync;
    logic [1:0] next_ref_sync;
    logic [1:0] next_rel_sync;
    logic       next_supply_ok;

    always_comb begin
        next_ref_sync = {ref_sync[0], above_ref_i};
        next_rel_sync = {rel_sync[0], above_release_i};
        next_supply_ok = supply_ok_o;
        if (!ref_sync[1]) begin
            next_supply_ok = 1'b0;
        end else if (rel_sync[1]) begin
            next_supply_ok = 1'b1;
        end
        if (!rstn_i) begin
            next_ref_sync  = 2'h0;
            next_rel_sync  = 2'h0;
            next_supply_ok = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        ref_sync    <= next_ref_sync;
        rel_sync    <= next_rel_sync;
        supply_ok_o <= next_supply_ok;
    end

endmodule : supply_level_filter

//--- design/supply_supervisor_window_watchdog.sv
// Supply supervisor with windowed watchdog and three-clear enable gate.
// Assumes comparator results and the clear pin arrive asynchronously.
//
// Function
// - After the supply recovers, the hold output stays low for the startup time before release.
// - The hold output is driven low whenever the supply is below the reference.
// - A clear during the closed window causes a watchdog reset.
// - No clear before the open window ends causes a watchdog reset.
// - The enable output stays inactive until three consecutive valid clears.
// - Reset asserts below the reference and releases above reference plus hysteresis.
// - Each restart runs 0.8 periods closed then 0.4 periods open.
// - A watchdog reset pulse lasts one fortieth of the period.
// - The startup hold time equals the watchdog period.
`timescale 1ns/100ps
module supply_supervisor_window_watchdog
    import supervisor_pkg::*;
#(
    parameter int unsigned WD_PERIOD_CYCLES = WD_PERIOD_CYC
)
(
    // Clock and reset
    input  wire logic SYS_CLK_I,
    input  wire logic RSTN_I,
    // Supply comparator results
    input  wire logic SENSE_ABOVE_REF_I,
    input  wire logic SENSE_ABOVE_RELEASE_I,
    // Watchdog clear from host
    input  wire logic WD_KICK_N_I,
    // Open-drain system hold
    output logic      SYSTEM_HOLD_N_O,
    output logic      SYSTEM_HOLD_OE_N_O,
    // System enable
    output logic      SYSTEM_ENABLE_N_O
);

    // ------------------------------------------------------------------
    // Derived cycle counts
    // ------------------------------------------------------------------
    localparam logic [31:0] PERIOD_CYC  = WD_PERIOD_CYCLES;
    localparam logic [31:0] STARTUP_CYC = PERIOD_CYC;
    localparam logic [31:0] CLOSED_CYC  =
        period_part(PERIOD_CYC, CLOSED_NUM, CLOSED_DEN);
    localparam logic [31:0] OPEN_CYC    =
        period_part(PERIOD_CYC, OPEN_NUM, OPEN_DEN);
    localparam logic [31:0] PULSE_CYC   =
        period_part(PERIOD_CYC, PULSE_NUM, PULSE_DEN);

    // ------------------------------------------------------------------
    // Supply qualification
    // ------------------------------------------------------------------
    logic supply_ok;

    supply_level_filter u_level (
        .clk_i           (SYS_CLK_I),
        .rstn_i          (RSTN_I),
        .above_ref_i     (SENSE_ABOVE_REF_I),
        .above_release_i (SENSE_ABOVE_RELEASE_I),
        .supply_ok_o     (supply_ok)
    );

    // ------------------------------------------------------------------
    // Clear pin synchroniser and falling-edge detect
    // ------------------------------------------------------------------
    logic [2:0] kick_sync;
    logic [2:0] next_kick_sync;
    logic       kick;

    always_comb begin
        next_kick_sync = {kick_sync[1:0], WD_KICK_N_I};
        if (!RSTN_I) begin
            next_kick_sync = 3'h7;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        kick_sync <= next_kick_sync;
    end

    // Host pulses the pin low to restart
    assign kick = kick_sync[2] & ~kick_sync[1];

    // ------------------------------------------------------------------
    // Window sequencer
    // ------------------------------------------------------------------
    wd_state_type state;
    wd_state_type next_state;
    logic [31:0]  count;
    logic [31:0]  next_count;
    logic [1:0]   kicks;
    logic [1:0]   next_kicks;
    logic         hold_n;
    logic         next_hold_n;
    logic         enable_n;
    logic         next_enable_n;

    always_comb begin
        next_state = state;
        next_count = count + 32'h1;
        next_kicks = kicks;
        case (state)
            ST_STARTUP: begin
                if (count >= STARTUP_CYC - 32'h1) begin
                    next_state = ST_CLOSED;
                    next_count = 32'h0;
                end
            end
            ST_CLOSED: begin
                if (kick) begin
                    next_state = ST_PULSE;
                    next_count = 32'h0;
                    next_kicks = 2'h0;
                end else if (count >= CLOSED_CYC - 32'h1) begin
                    next_state = ST_OPEN;
                    next_count = 32'h0;
                end
            end
            ST_OPEN: begin
                if (kick) begin
                    next_state = ST_CLOSED;
                    next_count = 32'h0;
                    if (kicks != KICKS_FOR_ENABLE) begin
                        next_kicks = kicks + 2'h1;
                    end
                end else if (count >= OPEN_CYC - 32'h1) begin
                    next_state = ST_PULSE;
                    next_count = 32'h0;
                    next_kicks = 2'h0;
                end
            end
            ST_PULSE: begin
                if (count >= PULSE_CYC - 32'h1) begin
                    next_state = ST_CLOSED;
                    next_count = 32'h0;
                end
            end
            default: begin
                next_state = ST_STARTUP;
                next_count = 32'h0;
                next_kicks = 2'h0;
            end
        endcase
        if (!supply_ok || !RSTN_I) begin
            next_state = ST_STARTUP;
            next_count = 32'h0;
            next_kicks = 2'h0;
        end
        // Hold low while starting up or pulsing
        next_hold_n = (next_state == ST_CLOSED) ||
                      (next_state == ST_OPEN);
        next_enable_n = !(next_hold_n &&
                          next_kicks == KICKS_FOR_ENABLE);
    end

    always_ff @(posedge SYS_CLK_I) begin
        state    <= next_state;
        count    <= next_count;
        kicks    <= next_kicks;
        hold_n   <= next_hold_n;
        enable_n <= next_enable_n;
    end

    // Open drain: drive low only while holding
    assign SYSTEM_HOLD_N_O    = hold_n;
    assign SYSTEM_HOLD_OE_N_O = hold_n;
    assign SYSTEM_ENABLE_N_O  = enable_n;

endmodule : supply_supervisor_window_watchdog

//--- tb/supervisor_asserts.sv
// Checker for the supervisor outputs, bound to the top module.
// Assumes the supply stays good while the host sends clears.
`timescale 1ns/100ps
module supervisor_asserts #(
    parameter int unsigned WD_PERIOD_CYCLES = 400
) (
    input  wire logic SYS_CLK_I,
    input  wire logic RSTN_I,
    input  wire logic SENSE_ABOVE_REF_I,
    input  wire logic SENSE_ABOVE_RELEASE_I,
    input  wire logic WD_KICK_N_I,
    input  wire logic SYSTEM_HOLD_N_O,
    input  wire logic SYSTEM_HOLD_OE_N_O,
    input  wire logic SYSTEM_ENABLE_N_O
);
    localparam int CL = WD_PERIOD_CYCLES * 4 / 5;
    localparam int OP = WD_PERIOD_CYCLES * 2 / 5;
    localparam int PU = WD_PERIOD_CYCLES / 40;
    int  lo;
    int  hi;
    int  good;
    wire win = hi >= CL + 8 && hi <= CL + OP - 8;
    // Low time, time since restart, valid clears
    always_ff @(posedge SYS_CLK_I) begin
        lo <= (!RSTN_I || SYSTEM_HOLD_N_O) ? 0 : lo + 1;
        if (!RSTN_I || !SYSTEM_HOLD_N_O || $fell(WD_KICK_N_I))
            hi <= 0;
        else
            hi <= hi + 1;
        if (!RSTN_I || !SYSTEM_HOLD_N_O)
            good <= 0;
        else if ($fell(WD_KICK_N_I) && win)
            good <= good + 1;
    end
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);
    a_low_supply: assert property (
        (!SENSE_ABOVE_REF_I)[*4] |=> !SYSTEM_HOLD_N_O) else $error("no hold");
    a_release_time: assert property (
        $rose(SYSTEM_HOLD_N_O) |-> lo == PU || lo >= WD_PERIOD_CYCLES)
        else $error("hold released at wrong time");
    a_early_kick: assert property (
        $fell(WD_KICK_N_I) && SYSTEM_HOLD_N_O && hi < CL - 8
        |-> ##[1:8] !SYSTEM_HOLD_N_O) else $error("early clear missed");
    a_kick_accepted: assert property (
        $fell(WD_KICK_N_I) && SYSTEM_HOLD_N_O && win
        |=> SYSTEM_HOLD_N_O[*8]) else $error("open clear refused");
    a_late_reset: assert property (
        SYSTEM_HOLD_N_O |-> hi <= CL + OP + 8) else $error("no timeout");
    a_enable_gate: assert property (
        !SYSTEM_ENABLE_N_O |-> good >= 3) else $error("enable too soon");
    a_third_kick: assert property (
        $fell(WD_KICK_N_I) && SYSTEM_HOLD_N_O && win && good == 2
        |-> ##[1:8] !SYSTEM_ENABLE_N_O) else $error("enable missing");
    a_fault_clears: assert property (
        !SYSTEM_HOLD_N_O |-> SYSTEM_ENABLE_N_O) else $error("enable held");
endmodule : supervisor_asserts
bind supply_supervisor_window_watchdog supervisor_asserts #(
    .WD_PERIOD_CYCLES(WD_PERIOD_CYCLES)) supervisor_asserts_inst (
    .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I),
    .SENSE_ABOVE_REF_I(SENSE_ABOVE_REF_I), .WD_KICK_N_I(WD_KICK_N_I),
    .SENSE_ABOVE_RELEASE_I(SENSE_ABOVE_RELEASE_I),
    .SYSTEM_HOLD_N_O(SYSTEM_HOLD_N_O), .SYSTEM_HOLD_OE_N_O(SYSTEM_HOLD_OE_N_O),
    .SYSTEM_ENABLE_N_O(SYSTEM_ENABLE_N_O));

//--- tb/host_kick_model.sv
// Host model: pulses the clear pin low for four cycles on request.
// Assumes the bench spaces the requests.
`timescale 1ns/100ps
module host_kick_model (
    input  wire logic clk_i,
    input  wire logic req_i,
    output logic      kick_n_o
);
    logic [2:0] cnt = 3'h0;
    always_ff @(posedge clk_i) begin
        if (req_i)
            cnt <= 3'h4;
        else if (cnt != 3'h0)
            cnt <= cnt - 3'h1;
    end
    assign kick_n_o = (cnt == 3'h0);
endmodule : host_kick_model

//--- tb/supply_supervisor_window_watchdog_bench.sv
// Bench for the supervisor: supply loss, window clears and timeouts.
// Assumes the host model pulses the clear pin on request.
`timescale 1ns/100ps
module supply_supervisor_window_watchdog_bench;
    import supervisor_pkg::*;
    localparam int WD = 400;
    localparam int CL = WD * 4 / 5;
    localparam int OP = WD * 2 / 5;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       ref_ok = 1'b1;
    logic       rel_ok = 1'b1;
    logic       req = 1'b0;
    logic [7:0] seed = 8'h39;
    wire        kick_n;
    wire        hold_n;
    wire        hold_oe_n;
    wire        en_n;
    wire        pin = hold_oe_n ? 1'b1 : 1'b0;
    int         err_count = 0;
    int         compares = 0;
    int         n;
    supply_supervisor_window_watchdog #(.WD_PERIOD_CYCLES(WD))
    supply_supervisor_window_watchdog_inst (
        .SYS_CLK_I(clk), .RSTN_I(rst_n), .SENSE_ABOVE_REF_I(ref_ok),
        .SENSE_ABOVE_RELEASE_I(rel_ok), .WD_KICK_N_I(kick_n),
        .SYSTEM_HOLD_N_O(hold_n), .SYSTEM_HOLD_OE_N_O(hold_oe_n),
        .SYSTEM_ENABLE_N_O(en_n));
    host_kick_model host_kick_model_inst (
        .clk_i(clk), .req_i(req), .kick_n_o(kick_n));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic test_done();
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    // Count cycles until the pin reaches a level, bounded
    task automatic wait_pin(input logic lvl, input int lim);
        n = 0;
        while (pin !== lvl) begin
            tick(1);
            n++;
            if (n > lim) begin
                err_count++;
                test_done();
            end
        end
    endtask : wait_pin
    task automatic kick(input int after);
        tick(after);
        req = 1'b1;
        tick(1);
        req = 1'b0;
    endtask : kick
    initial begin
        tick(4);
        check("enable in reset", en_n, 1'b1);
        check("hold in reset", pin, 1'b0);
        check("hold value in reset", hold_n, 1'b0);
        rst_n = 1'b1;
        wait_pin(1'b1, 1000);
        check("startup hold", n >= WD && n <= WD + 6, 1'b1);
        for (int i = 0; i < 3; i++) begin
            check("enable early", en_n, 1'b1);
            seed = lfsr(seed);
            kick(CL + 10 + seed % (OP - 30));
        end
        tick(8);
        check("enable on", en_n, 1'b0);
        check("hold kept", pin, 1'b1);
        wait_pin(1'b0, CL + OP + 20);
        check("timeout", n >= CL + OP - 10 && n <= CL + OP, 1'b1);
        check("enable off", en_n, 1'b1);
        wait_pin(1'b1, 100);
        check("pulse width", n, WD / 40);
        seed = lfsr(seed);
        kick(seed % (CL - 40));
        wait_pin(1'b0, 8);
        check("early clear", pin, 1'b0);
        wait_pin(1'b1, 100);
        ref_ok = 1'b0;
        rel_ok = 1'b0;
        wait_pin(1'b0, 8);
        check("supply drop", n, 4);
        tick(20);
        ref_ok = 1'b1;
        tick(60);
        check("hysteresis", pin, 1'b0);
        rel_ok = 1'b1;
        wait_pin(1'b1, 1000);
        check("recovery", n >= WD && n <= WD + 6, 1'b1);
        // Enable the system again, then reset it in mid-run
        for (int i = 0; i < 3; i++) begin
            kick(CL + 20);
        end
        tick(8);
        check("enable before reset", en_n, 1'b0);
        rst_n = 1'b0;
        tick(4);
        check("enable after reset", en_n, 1'b1);
        check("hold after reset", hold_n, 1'b0);
        rst_n = 1'b1;
        wait_pin(1'b1, 1000);
        check("restart hold", n >= WD && n <= WD + 6, 1'b1);
        check("hold value", hold_n, 1'b1);
        check("enable stays off", en_n, 1'b1);
        test_done();
    end
endmodule : supply_supervisor_window_watchdog_bench
